// ### mod_source.sv
`timescale 1ns/1ps
`default_nettype none
module mod_source (
	// clock
	input  wire logic               clk_i,
	// requested levels
	input  wire logic               key_lvl_i,
	input  wire logic signed [15:0] lvl_i,
	// pins toward the block
	output logic                    key_trig_o,
	output logic signed [15:0]      ext_mod_o
);
	// logic-level keying source and sampled analog source, updated after each rising edge
	always @(posedge clk_i)
	begin
		key_trig_o <= key_lvl_i;
		ext_mod_o <= lvl_i;
	end
endmodule // mod_source
`default_nettype wire

// ### test_waveform_modulation_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_waveform_modulation_control;
	logic               clk_i, rst_i, cyc_i, stb_i, we_i, key_lvl;
	logic [7:0]         adr_i;
	logic [3:0]         sel_i;
	logic [31:0]        dat_i, q;
	logic signed [15:0] lvl;
	logic [15:0]        a, d, o, p1, p2;
	wire logic [31:0]   dat_o;
	wire logic          ack_o, key_trig_i, int_mod_sync_o, conflict_o, mod_active_o;
	wire logic signed [15:0] ext_mod_i;
	wire logic [15:0]   phase_o;
	wire logic signed [17:0] amplitude_o, offset_o;
	int                 miscompares, n_compared, i;
	// expect bit, type, shape
	localparam logic [15:0] refuse_tbl [0:20] = '{16'ha005, 16'ha004, 16'ha006, 16'ha021,
		16'ha051, 16'hc007, 16'hc008, 16'hc121, 16'hc051, 16'hb005, 16'hb006, 16'hb121,
		16'hb007, 16'hd006, 16'hd221, 16'he006, 16'he221, 16'hf321, 16'h7006, 16'h2011,
		16'h4001};
	mod_source u_mod_source (.clk_i(clk_i), .key_lvl_i(key_lvl), .lvl_i(lvl),
		.key_trig_o(key_trig_i), .ext_mod_o(ext_mod_i));
	waveform_modulation_control u_waveform_modulation_control (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .key_trig_i(key_trig_i), .ext_mod_i(ext_mod_i),
		.phase_o(phase_o), .amplitude_o(amplitude_o), .offset_o(offset_o),
		.int_mod_sync_o(int_mod_sync_o), .conflict_o(conflict_o), .mod_active_o(mod_active_o));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// control word: enabled, external source, positive polarity
	function automatic logic [31:0] ctl(input logic [2:0] t, input logic [31:0] x);
		return {29'h0, t} | 32'h68 | x;
	endfunction
	function automatic logic [31:0] half(input logic [15:0] v);
		return {17'h0, v[15:1]};
	endfunction
	// full-scale results may fall short by two counts of truncation
	function automatic logic [31:0] near(input logic signed [31:0] v,
		input logic signed [31:0] e);
		return {31'h0, v >= e - 32'sh2 && v <= e};
	endfunction
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= wd;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			miscompares++;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic key(input logic v);
		@(posedge clk_i);
		key_lvl <= v;
		cycles(8);
	endtask
	initial
	begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, key_lvl} = 4'h0;
		adr_i = 8'h00;
		sel_i = 4'hf;
		dat_i = 32'h0;
		lvl = 16'sh0;
		void'($urandom(90555));
		cycles(4);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		chk("control", 32'h0000_0040, q);
		wb(1'b1, 8'hfc, 32'hffff_ffff);
		wb(1'b0, 8'hfc, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
		for (i = 0; i < 21; i++)
		begin
			wb(1'b1, 8'h04, {21'h0, refuse_tbl[i][10:0]});
			wb(1'b1, 8'h00, ctl(refuse_tbl[i][14:12], 32'h0));
			wb(1'b0, 8'h28, 32'h0);
			chk("status conflict", {31'h0, refuse_tbl[i][15]}, {31'h0, q[1]});
			chk("conflict", {31'h0, refuse_tbl[i][15]}, {31'h0, conflict_o});
		end
		$display("test refusals done");
		d = 16'($urandom_range(1, 65535));
		wb(1'b1, 8'h10, {16'h0, d});
		wb(1'b1, 8'h04, 32'h1);
		wb(1'b1, 8'h00, ctl(3'h4, 32'h0));
		key(1'b0);
		chk("psk low", 32'h0, {16'h0, phase_o});
		key(1'b1);
		chk("psk high", {16'h0, d}, {16'h0, phase_o});
		wb(1'b1, 8'h00, ctl(3'h4, 32'h0) & ~32'h40);
		cycles(4);
		chk("psk neg high", 32'h0, {16'h0, phase_o});
		key(1'b0);
		chk("psk neg low", {16'h0, d}, {16'h0, phase_o});
		$display("test phase keying done");
		wb(1'b1, 8'h0c, 32'h0001_0000);
		wb(1'b1, 8'h00, ctl(3'h2, 32'h100));
		wb(1'b0, 8'h28, 32'h0);
		chk("int wave", 32'h1, {29'h0, q[5:3]});
		key(1'b0);
		p1 = phase_o;
		cycles(4);
		chk("fsk carrier", {16'h0, p1}, {16'h0, phase_o});
		key(1'b1);
		p1 = phase_o;
		cycles(4);
		chk("fsk hop", {16'h0, 16'(p1 + 16'h4)}, {16'h0, phase_o});
		key(1'b0);
		p2 = 16'(phase_o - p1);
		chk("fsk continuous", 32'h1, {31'h0, p2 >= 16'h8 && p2 <= 16'h14});
		wb(1'b1, 8'h1c, 32'h8000);
		cycles(2);
		chk("int sync low", 32'h0, {31'h0, int_mod_sync_o});
		wb(1'b1, 8'h1c, 32'h0);
		wb(1'b1, 8'h00, ctl(3'h2, 32'h0) & ~32'h20);
		wb(1'b0, 8'h28, 32'h0);
		chk("int key", 32'h1, {31'h0, int_mod_sync_o & q[2]});
		$display("test frequency keying done");
		a = 16'($urandom_range(2, 65535));
		wb(1'b1, 8'h20, {16'h0, a});
		wb(1'b1, 8'h14, $urandom_range(1, 100));
		wb(1'b1, 8'h00, ctl(3'h5, 32'h10));
		cycles(4);
		chk("am stopped", half(a), {14'h0, amplitude_o});
		wb(1'b1, 8'h14, 32'h0);
		wb(1'b1, 8'h00, ctl(3'h5, 32'h0));
		lvl <= 16'($urandom);
		cycles(4);
		chk("am zero depth", half(a), {14'h0, amplitude_o});
		wb(1'b1, 8'h14, 32'h64);
		lvl <= 16'sh7fff;
		cycles(4);
		chk("am crest", 32'h1, near(amplitude_o, {16'h0, a}));
		wb(1'b1, 8'h00, ctl(3'h6, 32'h0));
		lvl <= 16'sh8000;
		cycles(4);
		chk("amsc inverted", 32'h0 - {16'h0, a}, 32'(amplitude_o));
		lvl <= 16'sh7fff;
		cycles(4);
		chk("amsc crest", 32'h1, near(amplitude_o, {16'h0, a}));
		$display("test amplitude done");
		wb(1'b1, 8'h00, ctl(3'h3, 32'h0));
		lvl <= 16'sh0;
		cycles(4);
		p1 = phase_o;
		lvl <= 16'sh8000;
		cycles(4);
		chk("pm trough", {16'h0, 16'(p1 - d)}, {16'h0, phase_o});
		lvl <= 16'sh7fff;
		cycles(4);
		chk("pm crest", 32'h1, near({16'h0, 16'(phase_o - p1)}, {16'h0, d}));
		$display("test phase modulation done");
		o = 16'($urandom_range(0, 16383));
		d = 16'($urandom_range(2, 16383));
		wb(1'b1, 8'h10, {16'h0, d});
		wb(1'b1, 8'h24, {16'h0, o});
		wb(1'b1, 8'h04, 32'h6);
		wb(1'b1, 8'h00, ctl(3'h7, 32'h0));
		lvl <= 16'sh7fff;
		cycles(6);
		chk("offset up", 32'h1, near(offset_o, {16'h0, o} + {16'h0, d}));
		lvl <= 16'sh8000;
		cycles(6);
		chk("offset down", {16'h0, o} - {16'h0, d}, 32'(offset_o));
		$display("test offset done");
		final_report;
	end
	initial
	begin
		#1000000;
		miscompares++;
		final_report;
	end
endmodule // test_waveform_modulation_control
`default_nettype wire

// ### waveform_modulation_control.v
`timescale 1ns/1ps
`default_nettype none
`include "waveform_modulation_control_defines.vh"

module waveform_modulation_control #(
	parameter ACC_W = 32,
	parameter VAL_W = 16
) (
	// clock and reset
	input  wire                    clk_i,
	input  wire                    rst_i,
	// wishbone slave
	input  wire                    cyc_i,
	input  wire                    stb_i,
	input  wire                    we_i,
	input  wire [7:0]              adr_i,
	input  wire [3:0]              sel_i,
	input  wire [31:0]             dat_i,
	output reg  [31:0]             dat_o,
	output reg                     ack_o,
	// modulating inputs
	input  wire                    key_trig_i,
	input  wire signed [VAL_W-1:0] ext_mod_i,
	// synthesizer controls
	output reg  [VAL_W-1:0]        phase_o,
	output reg  signed [VAL_W+1:0] amplitude_o,
	output reg  signed [VAL_W+1:0] offset_o,
	output reg                     int_mod_sync_o,
	output reg                     conflict_o,
	output reg                     mod_active_o
);

	reg  [31:0]            control_reg;
	reg  [10:0]            shape_reg;
	reg  [ACC_W-1:0]       carrier_freq_reg;
	reg  [ACC_W-1:0]       keying_alternate_frequency_reg;
	reg  [VAL_W-1:0]       deviation_reg;
	reg  [6:0]             depth_reg;
	reg  [ACC_W-1:0]       internal_mod_frequency_reg;
	reg  [VAL_W-1:0]       internal_mod_phase_reg;
	reg  [VAL_W-1:0]       amp_set_reg;
	reg  signed [VAL_W-1:0] offset_set_reg;
	reg  [ACC_W-1:0]       phase_acc_reg;
	reg  [ACC_W-1:0]       int_acc_reg;
	reg  [15:0]            lfsr_reg;
	reg  [2:0]             trig_sync_reg;
	reg                    trig_level_reg;

	wire [2:0] modulation_type_select = control_reg[`CTL_TYPE_LSB +: 3];
	wire       mod_enable = control_reg[`CTL_ENABLE_BIT];
	wire       mod_stop   = control_reg[`CTL_STOP_BIT];
	wire       pol_pos    = control_reg[`CTL_POL_POS_BIT];
	wire [3:0] wave       = shape_reg[`SHP_WAVE_LSB +: 4];
	wire [1:0] osc_mode   = shape_reg[`SHP_OSC_LSB +: 2];
	wire [1:0] burst_sty  = shape_reg[`SHP_BURST_LSB +: 2];
	wire [2:0] target     = shape_reg[`SHP_TARGET_LSB +: 3];
	wire       in_sweep   = (osc_mode == `OSC_SWEEP);
	wire       in_burst   = (osc_mode == `OSC_BURST);
	wire       keying     = (modulation_type_select == `TYPE_FSK) ||
	                        (modulation_type_select == `TYPE_PSK);

	// internal source is blocked during sweep
	wire ext_source = control_reg[`CTL_EXT_SRC_BIT] | in_sweep;

	// keying forces the internal square
	wire [2:0] internal_mod_waveform = keying ? `IW_SQUARE :
	                                   control_reg[`CTL_INTWAVE_LSB +: 3];

	// settings conflict check
	wire no_freq_wave = (wave == `WAVE_NOISE) || (wave == `WAVE_PULSE) ||
	                    (wave == `WAVE_DC);
	wire no_phase_wave = (wave == `WAVE_ARB) || (wave == `WAVE_PWF) ||
	                     (wave == `WAVE_NOISE) || (wave == `WAVE_DC);
	wire burst_bad = in_burst && (burst_sty != `BURST_AUTO);
	wire swp_freq  = in_sweep && (target == `TGT_FREQ);
	wire swp_phase = in_sweep && (target == `TGT_PHASE);
	wire swp_amp   = in_sweep && (target == `TGT_AMP);
	wire swp_ofs   = in_sweep && (target == `TGT_OFFSET);
	reg  conflict;

	always @*
	begin
		case (modulation_type_select)
			`TYPE_FM:   conflict = no_freq_wave | swp_freq;
			`TYPE_FSK:  conflict = no_freq_wave | burst_bad | swp_freq;
			`TYPE_PM:   conflict = no_phase_wave | swp_phase;
			`TYPE_PSK:  conflict = no_phase_wave | burst_bad | swp_phase;
			`TYPE_AM:   conflict = (wave == `WAVE_DC) | swp_amp;
			`TYPE_AMSC: conflict = (wave == `WAVE_DC) | swp_amp;
			`TYPE_OFFSET_MOD: conflict = swp_ofs;
			default:    conflict = 1'b0;
		endcase
	end

	// modulation only runs while valid; resumes as soon as valid again
	wire active = mod_enable && !mod_stop && !conflict &&
	              (modulation_type_select != `TYPE_OFF);

	// internal modulating waveform, signed full scale
	wire [VAL_W-1:0] int_ph = int_acc_reg[ACC_W-1 -: VAL_W] + internal_mod_phase_reg;
	reg  signed [VAL_W-1:0] int_val;

	always @*
	begin
		case (internal_mod_waveform)
			`IW_SQUARE:   int_val = int_ph[VAL_W-1] ? {1'b1, {(VAL_W-1){1'b0}}} :
			                                          {1'b0, {(VAL_W-1){1'b1}}};
			`IW_UPRAMP:   int_val = int_ph ^ {1'b1, {(VAL_W-1){1'b0}}};
			`IW_DNRAMP:   int_val = ~(int_ph ^ {1'b1, {(VAL_W-1){1'b0}}});
			`IW_NOISE:    int_val = lfsr_reg[VAL_W-1:0];
			default:      int_val = (int_ph[VAL_W-1] ? ~{int_ph[VAL_W-2:0], 1'b0} :
			                         {int_ph[VAL_W-2:0], 1'b0}) ^
			                        {1'b1, {(VAL_W-1){1'b0}}};
		endcase
	end

	wire signed [VAL_W-1:0] mod_val = ext_source ? ext_mod_i : int_val;

	// keying state: internal square or synchronised trigger with polarity
	wire int_key = ~int_ph[VAL_W-1];
	wire key_state = ext_source ? (trig_level_reg ~^ pol_pos) : int_key;

	// scaled deviation: full-scale input gives full deviation
	wire signed [2*VAL_W+1:0] dev_prod = mod_val * $signed({2'b00, deviation_reg});
	// full scale is 2^(VAL_W-1), so dropping VAL_W-1 bits leaves the deviation
	wire signed [VAL_W+1:0]   dev_scaled = dev_prod[2*VAL_W -: VAL_W+2];

	// depth scaling, signed signal times depth over 100
	wire signed [VAL_W+7:0] depth_prod = mod_val * $signed({1'b0, depth_reg});
	wire signed [VAL_W+7:0] depth_div = depth_prod / $signed(`DEPTH_FULL);
	wire signed [VAL_W:0]   dm = depth_div[VAL_W:0];
	wire signed [2*VAL_W+2:0] am_prod = dm * $signed({1'b0, amp_set_reg});
	wire signed [VAL_W+1:0] half_amp = $signed({3'b000, amp_set_reg[VAL_W-1:1]});
	// same scaling: full-scale signal at full depth gives the amplitude setting
	wire signed [VAL_W+1:0] am_dsb = am_prod[2*VAL_W -: VAL_W+2];

	// next phase increment, phase offset, amplitude and offset
	reg  [ACC_W-1:0] inc_next;
	reg  [VAL_W-1:0] phase_ofs_next;
	reg  signed [VAL_W+1:0] amp_next;
	reg  signed [VAL_W+1:0] ofs_next;
	wire [ACC_W-1:0] fm_shift = {{(ACC_W-VAL_W-2){dev_scaled[VAL_W+1]}}, dev_scaled};

	always @*
	begin
		inc_next = carrier_freq_reg;
		phase_ofs_next = {VAL_W{1'b0}};
		amp_next = $signed({2'b00, amp_set_reg});
		ofs_next = $signed({{2{offset_set_reg[VAL_W-1]}}, offset_set_reg});
		if ((modulation_type_select == `TYPE_AM) && !conflict)
			amp_next = half_amp;
		if (active)
		begin
			case (modulation_type_select)
				`TYPE_FM:   inc_next = carrier_freq_reg + fm_shift;
				`TYPE_FSK:  inc_next = key_state ? keying_alternate_frequency_reg :
				                       carrier_freq_reg;
				`TYPE_PM:   phase_ofs_next = dev_scaled[VAL_W-1:0];
				`TYPE_PSK:  phase_ofs_next = key_state ? deviation_reg :
				                             {VAL_W{1'b0}};
				`TYPE_AM:   amp_next = half_amp + (am_dsb >>> 1);
				`TYPE_AMSC: amp_next = am_dsb;
				`TYPE_OFFSET_MOD: ofs_next = ofs_next + dev_scaled;
				default:    inc_next = carrier_freq_reg;
			endcase
		end
	end

	// phase generation and outputs
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phase_acc_reg  <= {ACC_W{1'b0}};
			int_acc_reg    <= {ACC_W{1'b0}};
			lfsr_reg       <= 16'h0001;
			trig_sync_reg  <= 3'h0;
			trig_level_reg <= 1'b0;
			phase_o        <= {VAL_W{1'b0}};
			amplitude_o    <= {(VAL_W+2){1'b0}};
			offset_o       <= {(VAL_W+2){1'b0}};
			int_mod_sync_o <= 1'b0;
			conflict_o     <= 1'b0;
			mod_active_o   <= 1'b0;
		end
		else
		begin
			// only the increment changes, so phase stays continuous
			phase_acc_reg  <= phase_acc_reg + inc_next;
			int_acc_reg    <= int_acc_reg + internal_mod_frequency_reg;
			// free-running noise for the internal noise waveform
			lfsr_reg       <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
			                   lfsr_reg[12] ^ lfsr_reg[10]};
			trig_sync_reg  <= {trig_sync_reg[1:0], key_trig_i};
			// a new level counts once the last two stages agree
			if (trig_sync_reg[2] == trig_sync_reg[1])
				trig_level_reg <= trig_sync_reg[2];
			phase_o        <= phase_acc_reg[ACC_W-1 -: VAL_W] + phase_ofs_next;
			amplitude_o    <= amp_next;
			offset_o       <= ofs_next;
			int_mod_sync_o <= int_key;
			conflict_o     <= mod_enable && conflict;
			mod_active_o   <= active;
		end
	end

	// wishbone register access
	wire wb_req = cyc_i && stb_i && !ack_o;
	wire wb_wr  = wb_req && we_i;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  sel;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// merged write words, cut to each register's width
	wire [31:0] control_wr   = merge(control_reg, dat_i, sel_i);
	wire [31:0] shape_wr     = merge({21'h0, shape_reg}, dat_i, sel_i);
	wire [31:0] deviation_wr = merge({16'h0, deviation_reg}, dat_i, sel_i);
	wire [31:0] int_phase_wr = merge({16'h0, internal_mod_phase_reg}, dat_i, sel_i);
	wire [31:0] amp_wr       = merge({16'h0, amp_set_reg}, dat_i, sel_i);
	wire [31:0] offset_wr    = merge({16'h0, offset_set_reg}, dat_i, sel_i);
	// depth saturates at full scale, but only the low 7 bits of the write are compared, so larger values wrap
	wire [6:0]  depth_wr     = (dat_i[6:0] > `DEPTH_FULL) ? 7'h64 : dat_i[6:0];

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			control_reg                    <= `CTL_RESET;
			shape_reg                      <= 11'h000;
			carrier_freq_reg               <= {ACC_W{1'b0}};
			keying_alternate_frequency_reg <= {ACC_W{1'b0}};
			deviation_reg                  <= {VAL_W{1'b0}};
			depth_reg                      <= 7'h00;
			internal_mod_frequency_reg     <= {ACC_W{1'b0}};
			internal_mod_phase_reg         <= {VAL_W{1'b0}};
			amp_set_reg                    <= {VAL_W{1'b0}};
			offset_set_reg                 <= {VAL_W{1'b0}};
		end
		else if (wb_wr)
		begin
			case (adr_i)
				`OFS_CONTROL:
					control_reg <= control_wr & 32'h0000_03ff;
				`OFS_SHAPE:
					shape_reg <= shape_wr[10:0];
				`OFS_CARRIER_FREQ:
					carrier_freq_reg <= merge(carrier_freq_reg, dat_i, sel_i);
				`OFS_HOP_FREQ:
					keying_alternate_frequency_reg <=
						merge(keying_alternate_frequency_reg, dat_i, sel_i);
				`OFS_DEVIATION:
					deviation_reg <= deviation_wr[VAL_W-1:0];
				`OFS_DEPTH:
				begin
					if (sel_i[0])
						depth_reg <= depth_wr;
				end
				`OFS_INT_FREQ:
					internal_mod_frequency_reg <= merge(internal_mod_frequency_reg, dat_i, sel_i);
				`OFS_INT_PHASE:
					internal_mod_phase_reg <=
						int_phase_wr[VAL_W-1:0];
				`OFS_AMPLITUDE:
					amp_set_reg <= amp_wr[VAL_W-1:0];
				`OFS_OFFSET:
					offset_set_reg <= offset_wr[VAL_W-1:0];
				default:
					control_reg <= control_reg;
			endcase
		end
	end

	reg [31:0] rd_next;

	always @*
	begin
		case (adr_i)
			`OFS_CONTROL:      rd_next = {22'h0, control_reg[9:0]};
			`OFS_SHAPE:        rd_next = {21'h0, shape_reg};
			`OFS_CARRIER_FREQ: rd_next = carrier_freq_reg;
			`OFS_HOP_FREQ:     rd_next = keying_alternate_frequency_reg;
			`OFS_DEVIATION:    rd_next = {16'h0, deviation_reg};
			`OFS_DEPTH:        rd_next = {25'h0, depth_reg};
			`OFS_INT_FREQ:     rd_next = internal_mod_frequency_reg;
			`OFS_INT_PHASE:    rd_next = {16'h0, internal_mod_phase_reg};
			`OFS_AMPLITUDE:    rd_next = {16'h0, amp_set_reg};
			`OFS_OFFSET:       rd_next = {16'h0, offset_set_reg};
			`OFS_STATUS:       rd_next = {26'h0, internal_mod_waveform, key_state,
			                              conflict_o, mod_active_o};
			default:           rd_next = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= wb_req;
			dat_o <= wb_req ? rd_next : 32'h0000_0000;
		end
	end

endmodule // waveform_modulation_control
`default_nettype wire

// ### waveform_modulation_control_defines.vh
`ifndef WAVEFORM_MODULATION_CONTROL_DEFINES_VH
`define WAVEFORM_MODULATION_CONTROL_DEFINES_VH

// register byte offsets
`define OFS_CONTROL       8'h00
`define OFS_SHAPE         8'h04
`define OFS_CARRIER_FREQ  8'h08
`define OFS_HOP_FREQ      8'h0c
`define OFS_DEVIATION     8'h10
`define OFS_DEPTH         8'h14
`define OFS_INT_FREQ      8'h18
`define OFS_INT_PHASE     8'h1c
`define OFS_AMPLITUDE     8'h20
`define OFS_OFFSET        8'h24
`define OFS_STATUS        8'h28

// control fields
`define CTL_TYPE_LSB      0
`define CTL_ENABLE_BIT    3
`define CTL_STOP_BIT      4
`define CTL_EXT_SRC_BIT   5
`define CTL_POL_POS_BIT   6
`define CTL_INTWAVE_LSB   7
`define CTL_RESET         32'h0000_0040

// shape fields
`define SHP_WAVE_LSB      0
`define SHP_OSC_LSB       4
`define SHP_BURST_LSB     6
`define SHP_TARGET_LSB    8

// modulation types
`define TYPE_OFF          3'h0
`define TYPE_FM           3'h1
`define TYPE_FSK          3'h2
`define TYPE_PM           3'h3
`define TYPE_PSK          3'h4
`define TYPE_AM           3'h5
`define TYPE_AMSC         3'h6
`define TYPE_OFFSET_MOD   3'h7

// output waveforms
`define WAVE_SQUARE       4'h1
`define WAVE_PULSE        4'h4
`define WAVE_NOISE        4'h5
`define WAVE_DC           4'h6
`define WAVE_ARB          4'h7
`define WAVE_PWF          4'h8

// oscillation modes, burst style, sweep targets
`define OSC_BURST         2'h1
`define OSC_SWEEP         2'h2
`define BURST_AUTO        2'h0
`define TGT_FREQ          3'h0
`define TGT_PHASE         3'h1
`define TGT_AMP           3'h2
`define TGT_OFFSET        3'h3

// internal modulation waveforms
`define IW_SQUARE         3'h1
`define IW_TRIANGLE       3'h2
`define IW_UPRAMP         3'h3
`define IW_DNRAMP         3'h4
`define IW_NOISE          3'h5

// depth full scale in percent
`define DEPTH_FULL        8'h64

`endif

// ### waveform_modulation_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module modulation_monitor #(
	parameter VAL_W = 16
) (
	// clock, reset and bus
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	input wire logic                    cyc_i,
	input wire logic                    stb_i,
	input wire logic [31:0]             dat_o,
	input wire logic                    ack_o,
	// outputs
	input wire logic signed [VAL_W+1:0] amplitude_o,
	input wire logic                    conflict_o,
	input wire logic                    mod_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_idle_quiet: assert property (!cyc_i |=> !ack_o)
		else $error("ack while idle");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	a_conflict_excl: assert property (conflict_o |-> !mod_active_o)
		else $error("running while in conflict");
	a_conflict_stop: assert property ($rose(conflict_o) |-> !mod_active_o ##1 !mod_active_o)
		else $error("conflict did not stop modulation");
	a_reset_quiet: assert property ($past(rst_i) |->
		!ack_o && !conflict_o && !mod_active_o && amplitude_o == 0)
		else $error("outputs not cleared by reset");
endmodule // modulation_monitor
bind waveform_modulation_control modulation_monitor #(.VAL_W(VAL_W)) u_modulation_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
	.ack_o(ack_o), .amplitude_o(amplitude_o), .conflict_o(conflict_o),
	.mod_active_o(mod_active_o));
`default_nettype wire
